// ### src/glcd_ctrl.sv
// Purpose: host port, display ram, address counters and scan timing of a 64x48 lcd driver
// Assumes: host pins synchronous to mclk_i; strobe low time spans several clocks
// Notes: host transfers other than status reads queue in a small fifo drained at the internal operating rate; transfers made in standby or pin reset are dropped
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module glcd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } glcd_fifo_s;
  glcd_fifo_s s;
  glcd_fifo_s next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = s.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = s.cnt != '0;
  assign out_data_o = mem[s.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
    if (push) begin
      mem[s.wp] <= in_data_i;
    end
  end
endmodule : glcd_fifo

////////////////////////////////////////////////////////////////////////////////
module glcd_ctrl (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // device pins
  input wire logic rst_n_i,
  input wire logic standby_n_i,
  input wire logic [1:0] osc_frequency_straps_i,
  input wire logic [1:0] scan_duty_straps_i,
  // host port
  input wire logic data_sel_i,
  input wire logic write_n_i,
  input wire logic strobe_n_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  // lcd drive
  output logic [glcd_pkg::COLS-1:0] column_outputs_o,
  output logic [glcd_pkg::ROWS-1:0] row_outputs_o,
  output logic frame_pulse_o
);
  import glcd_pkg::*;

  typedef struct packed {
    logic strobe_q;
    logic [7:0] data_q;
    logic [7:0] dout;
    logic dout_oe;
    logic [7:0] out_reg;
    logic dir_up;
    logic sel_y;
    logic disp_on;
    logic [5:0] start_line;
    logic word8;
    logic [5:0] x;
    logic [3:0] y;
    logic [DIV_W-1:0] osc_cnt;
    logic [3:0] line_cnt;
    logic [5:0] line;
    logic [5:0] z;
    logic [ROWS-1:0] shifter;
    logic [COLS-1:0] line_data;
    logic [COLS-1:0] col;
    logic [ROWS-1:0] row;
    logic frame;
  } glcd_state_s;

  localparam glcd_state_s ST_RESET = '{
    dir_up: RST_DIR_UP, sel_y: RST_SEL_Y, disp_on: RST_DISP_ON, word8: RST_WORD8,
    // row walk starts on line 0, so rows are live before the first frame
    shifter: ROWS'(1),
    strobe_q: 1'b1, default: '0};

  glcd_state_s s;
  glcd_state_s next_s;
  logic [COLS-1:0] ram [ROWS];
  logic in_reset;
  logic active;
  logic rise;
  logic push_valid;
  logic [ENTRY_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [ENTRY_W-1:0] pop_data;
  logic osc_tick;
  logic line_tick;
  logic [DIV_W-1:0] osc_div;
  logic [5:0] duty_last;
  logic [6:0] base;
  logic [6:0] width;
  logic [COLS-1:0] cur_row;
  logic [COLS-1:0] wr_row;
  logic [7:0] rd_byte;
  logic ram_we;
  logic [7:0] status;
  logic [7:0] op;
  logic show;

  assign in_reset = reset_i || !rst_n_i;
  assign active = rst_n_i && standby_n_i;
  assign rise = !s.strobe_q && strobe_n_i;
  assign push_valid = rise && active && !(write_n_i && !data_sel_i);
  assign push_data = {(!data_sel_i ? GLCD_CMD : (write_n_i ? GLCD_RDAT : GLCD_WDAT)), s.data_q};
  assign osc_tick = s.osc_cnt == '0;
  assign line_tick = osc_tick && s.line_cnt == '0;
  // one entry per operating clock, so busy is real while the queue drains
  assign pop_ready = osc_tick;
  assign op = pop_data[7:0];

  glcd_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .reset_i(in_reset),
    .in_valid_i(push_valid),
    .in_ready_o(),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (osc_frequency_straps_i)
      2'h0: osc_div = OSC0_DIV;
      2'h1: osc_div = OSC1_DIV;
      2'h2: osc_div = OSC2_DIV;
      default: osc_div = OSC3_DIV;
    endcase
    case (scan_duty_straps_i)
      DUTY16: duty_last = DUTY16_LAST;
      DUTY32: duty_last = DUTY32_LAST;
      default: duty_last = ROW_LAST;
    endcase
  end

  // word placement within a row; page 10 in six-bit mode holds only 4 bits
  always_comb begin
    base = s.word8 ? {s.y, 3'h0} : 7'(s.y) * WORD6_BITS;
    width = s.word8 ? WORD8_BITS : WORD6_BITS;
    cur_row = ram[s.x];
    wr_row = cur_row;
    rd_byte = '0;
    for (int b = 0; b < COLS; b++) begin
      if (7'(b) >= base && 7'(b) < base + width) begin
        wr_row[b] = op[3'(7'(b) - base)];
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (7'(i) < width && base + 7'(i) < 7'(COLS)) begin
        rd_byte[i] = cur_row[6'(base + 7'(i))];
      end
    end
  end

  assign ram_we = pop_valid && pop_ready && glcd_kind_e'(pop_data[9:8]) == GLCD_WDAT;
  always_comb begin
    status = '0;
    status[ST_BUSY] = pop_valid;
    status[ST_WORD8] = s.word8;
    status[ST_DISP] = s.disp_on;
    status[ST_RST] = !rst_n_i;
    status[ST_SEL] = s.sel_y;
    status[ST_DIR] = s.dir_up;
  end
  assign show = s.disp_on && standby_n_i;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.strobe_q = strobe_n_i;
    next_s.frame = 1'b0;
    if (!strobe_n_i) begin
      next_s.data_q = host_data_bus_i;
    end
    // read drive follows strobe one clock late; released on all other cycles
    next_s.dout_oe = active && write_n_i && !strobe_n_i;
    next_s.dout = data_sel_i ? s.out_reg : status;
    next_s.osc_cnt = osc_tick ? osc_div - 1'b1 : s.osc_cnt - 1'b1;
    if (osc_tick) begin
      next_s.line_cnt = (s.line_cnt == '0) ? LINE_OSC_TICKS - 1'b1 : s.line_cnt - 1'b1;
    end
    if (pop_valid && pop_ready) begin
      case (glcd_kind_e'(pop_data[9:8]))
        GLCD_CMD: begin
          if (op[7:6] == CMD_XSET) begin
            if (op[5:0] <= ROW_LAST) next_s.x = op[5:0];
          end else if (op[7:6] == CMD_ZSET) begin
            if (op[5:0] <= ROW_LAST) next_s.start_line = op[5:0];
          end else if (op[7:5] == CMD_PAGE) begin
            if (op[3:0] <= (s.word8 ? PAGE_LAST8 : PAGE_LAST6)) next_s.y = op[3:0];
          end else if (op[7:2] == CMD_MODE) begin
            next_s.sel_y = op[1];
            next_s.dir_up = op[0];
          end else if (op[7:1] == CMD_DISP) begin
            next_s.disp_on = op[0];
          end else if (op[7:1] == CMD_WLEN) begin
            next_s.word8 = op[0];
          end
        end
        GLCD_WDAT, GLCD_RDAT: begin
          if (glcd_kind_e'(pop_data[9:8]) == GLCD_RDAT) begin
            next_s.out_reg = rd_byte;
          end
          if (s.sel_y) begin
            if (s.dir_up) begin
              next_s.y = (s.y >= (s.word8 ? PAGE_LAST8 : PAGE_LAST6)) ? '0 : s.y + 1'b1;
            end else begin
              next_s.y = (s.y == '0) ? (s.word8 ? PAGE_LAST8 : PAGE_LAST6) : s.y - 1'b1;
            end
          end else begin
            if (s.dir_up) begin
              next_s.x = (s.x == ROW_LAST) ? '0 : s.x + 1'b1;
            end else begin
              next_s.x = (s.x == '0) ? ROW_LAST : s.x - 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (line_tick) begin
      // a duty cut short mid-frame ends the frame at once instead of wrapping
      if (s.line >= duty_last) begin
        next_s.line = '0;
        next_s.z = s.start_line;
        next_s.shifter = ROWS'(1);
        next_s.frame = 1'b1;
      end else begin
        next_s.line = s.line + 1'b1;
        next_s.z = (s.z == ROW_LAST) ? '0 : s.z + 1'b1;
        // halves chain only when the duty needs more than 16 rows
        next_s.shifter[HALF_ROWS-1:0] = {s.shifter[HALF_ROWS-2:0], 1'b0};
        next_s.shifter[ROWS-1:HALF_ROWS] = {s.shifter[ROWS-2:HALF_ROWS],
          (duty_last > DUTY16_LAST) ? s.shifter[HALF_ROWS-1] : 1'b0};
      end
      next_s.line_data = ram[next_s.z];
    end
    next_s.col = show ? s.line_data : '0;
    next_s.row = show ? s.shifter : '0;
  end

  always_ff @(posedge mclk_i) begin
    if (in_reset) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
    if (ram_we && !in_reset) begin
      ram[s.x] <= wr_row;
    end
  end

  assign host_data_bus_o = s.dout;
  assign host_data_bus_oe_o = s.dout_oe;
  assign column_outputs_o = s.col;
  assign row_outputs_o = s.row;
  assign frame_pulse_o = s.frame;
endmodule : glcd_ctrl

// ### include/glcd_pkg.sv
// Purpose: shared constants and types for the graphic lcd ram/scan controller
// Assumes: 100 MHz mclk, all pins synchronous to it
// Notes: straps and bus pins are sampled as plain inputs
package glcd_pkg;
  localparam int MCLK_HZ = 100000000;
  // oscillator rates, in hertz (26.88, 53.76, 215.00, 430.10 kHz)
  localparam int OSC0_HZ = 26880;
  localparam int OSC1_HZ = 53760;
  localparam int OSC2_HZ = 215000;
  localparam int OSC3_HZ = 430100;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] OSC0_DIV = DIV_W'(MCLK_HZ / OSC0_HZ);
  localparam logic [DIV_W-1:0] OSC1_DIV = DIV_W'(MCLK_HZ / OSC1_HZ);
  localparam logic [DIV_W-1:0] OSC2_DIV = DIV_W'(MCLK_HZ / OSC2_HZ);
  localparam logic [DIV_W-1:0] OSC3_DIV = DIV_W'(MCLK_HZ / OSC3_HZ);
  localparam logic [3:0] LINE_OSC_TICKS = 4'h8;
  // geometry
  localparam int ROWS = 48;
  localparam int COLS = 64;
  localparam int HALF_ROWS = 24;
  localparam logic [5:0] ROW_LAST = 6'h2f;
  localparam logic [3:0] PAGE_LAST8 = 4'h7;
  localparam logic [3:0] PAGE_LAST6 = 4'ha;
  localparam logic [6:0] WORD8_BITS = 7'h08;
  localparam logic [6:0] WORD6_BITS = 7'h06;
  localparam logic [5:0] DUTY16_LAST = 6'h0f;
  localparam logic [5:0] DUTY32_LAST = 6'h1f;
  localparam logic [1:0] DUTY16 = 2'h0;
  localparam logic [1:0] DUTY32 = 2'h1;
  // fifo entry kinds
  typedef enum logic [1:0] {GLCD_CMD = 2'h0, GLCD_WDAT = 2'h1, GLCD_RDAT = 2'h2} glcd_kind_e;
  localparam int ENTRY_W = 10;
  localparam int FIFO_DEPTH = 4;
  // command field positions and codes
  localparam logic [6:0] CMD_WLEN = 7'h00;
  localparam logic [6:0] CMD_DISP = 7'h01;
  localparam logic [5:0] CMD_MODE = 6'h01;
  localparam logic [2:0] CMD_PAGE = 3'h1;
  localparam logic [1:0] CMD_ZSET = 2'h1;
  localparam logic [1:0] CMD_XSET = 2'h2;
  // status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_WORD8 = 6;
  localparam int ST_DISP = 5;
  localparam int ST_RST = 4;
  localparam int ST_SEL = 1;
  localparam int ST_DIR = 0;
  // reset values
  localparam logic RST_DIR_UP = 1'b1;
  localparam logic RST_SEL_Y = 1'b1;
  localparam logic RST_DISP_ON = 1'b0;
  localparam logic RST_WORD8 = 1'b1;
endpackage : glcd_pkg

// ### verif/glcd_ctrl_properties.sv
// Purpose: pin-level checks of the lcd controller host port and drive outputs
// Assumes: one clock domain, synchronous active-high reset_i
// Notes: bound to glcd_ctrl from the testbench top file
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module glcd_ctrl_checker (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // device pins
  input wire logic rst_n_i,
  input wire logic standby_n_i,
  input wire logic [1:0] osc_frequency_straps_i,
  input wire logic [1:0] scan_duty_straps_i,
  // host port
  input wire logic data_sel_i,
  input wire logic write_n_i,
  input wire logic strobe_n_i,
  input wire logic [7:0] host_data_bus_i,
  input wire logic [7:0] host_data_bus_o,
  input wire logic host_data_bus_oe_o,
  // lcd drive
  input wire logic [glcd_pkg::COLS-1:0] column_outputs_o,
  input wire logic [glcd_pkg::ROWS-1:0] row_outputs_o,
  input wire logic frame_pulse_o
);
  import glcd_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  AST_OE_CAUSE: assert property (host_data_bus_oe_o |-> !$past(strobe_n_i) && $past(write_n_i))
    else $error("bus driven without a read strobe");
  AST_OE_RISE: assert property (!strobe_n_i && write_n_i && standby_n_i && rst_n_i && !$past(reset_i)
    && $past(rst_n_i) |=> host_data_bus_oe_o) else $error("read strobe not answered");
  AST_OE_DROP: assert property (strobe_n_i |=> !host_data_bus_oe_o)
    else $error("bus not released after strobe");
  AST_STANDBY_IDLE: assert property (!standby_n_i |=> column_outputs_o == '0 && row_outputs_o == '0
    && !host_data_bus_oe_o) else $error("outputs active in standby");
  AST_RESET_PIN: assert property (!rst_n_i |=> column_outputs_o == '0 && row_outputs_o == '0
    && !frame_pulse_o && !host_data_bus_oe_o) else $error("outputs active in reset");
  AST_ROW_ONEHOT: assert property ($onehot0(row_outputs_o))
    else $error("more than one row selected");
  AST_FRAME_PULSE: assert property (frame_pulse_o |=> !frame_pulse_o [*8])
    else $error("frame pulse too long or too close");
  AST_STATUS_ZEROS: assert property (host_data_bus_oe_o && !$past(data_sel_i) |-> host_data_bus_o[3:2] == 2'b00)
    else $error("status filler bits not zero");
endmodule : glcd_ctrl_checker

// ### verif/glcd_host_model.sv
// Purpose: behavioural 80-style host driving the controller's parallel port
// Assumes: pins change at the falling clock edge, strobe low three clocks
// Notes: a released bus shows the inverse of the last byte, never a held copy
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module glcd_host_model (
  // clock
  input wire logic mclk_i,
  // host pins
  output logic data_sel_o,
  output logic write_n_o,
  output logic strobe_n_o,
  output logic [7:0] bus_o,
  // device answer
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i
);
  logic drv;
  logic [7:0] val;
  assign bus_o = dev_oe_i ? dev_data_i : (drv ? val : ~val);
  initial begin
    data_sel_o = 1'b0;
    write_n_o = 1'b1;
    strobe_n_o = 1'b1;
    drv = 1'b0;
    val = 8'h00;
  end
  task automatic xfer(input logic sel, input logic wr, input logic [7:0] b, output logic [7:0] rb);
    @(negedge mclk_i);
    data_sel_o = sel;
    write_n_o = !wr;
    val = b;
    drv = wr;
    strobe_n_o = 1'b0;
    repeat (3) @(posedge mclk_i);
    // sample off the edge, where the registered read drive has settled
    @(negedge mclk_i);
    rb = dev_oe_i ? dev_data_i : ~val;
    strobe_n_o = 1'b1;
    @(negedge mclk_i);
    drv = 1'b0;
  endtask : xfer
endmodule : glcd_host_model

// ### verif/glcd_ctrl_tb.sv
// Purpose: self-checking bench for the lcd controller with a behavioural ram model
// Assumes: host model drives pins at the falling edge
// Notes: fastest strap setting keeps command ticks short
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end

////////////////////////////////////////////////////////////////////////////////
module glcd_ctrl_tb;
  import glcd_pkg::*;
  logic mclk_i = 1'b0, reset_i = 1'b1, rst_n_i = 1'b1, standby_n_i = 1'b1;
  logic [1:0] freq_sel = 2'h3, duty_sel = 2'h2;
  logic data_sel, write_n, strobe_n, bus_oe, frame;
  logic [7:0] bus_in, bus_out, b, q;
  logic [63:0] cols, exp_row;
  logic [47:0] rows;
  logic [7:0] mem [48][11];
  int failures = 0, check_count = 0, cyc = 0, x, y, dir, sel, w8, t0;
  int divs[4] = '{3720, 1860, 465, 232};
  integer seed = 32'h987a294c;
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc++;
  glcd_ctrl dut (.mclk_i(mclk_i), .reset_i(reset_i), .rst_n_i(rst_n_i), .standby_n_i(standby_n_i),
    .osc_frequency_straps_i(freq_sel), .scan_duty_straps_i(duty_sel), .data_sel_i(data_sel),
    .write_n_i(write_n), .strobe_n_i(strobe_n), .host_data_bus_i(bus_in), .host_data_bus_o(bus_out),
    .host_data_bus_oe_o(bus_oe), .column_outputs_o(cols), .row_outputs_o(rows), .frame_pulse_o(frame));
  glcd_host_model host (.mclk_i(mclk_i), .data_sel_o(data_sel), .write_n_o(write_n), .strobe_n_o(strobe_n),
    .bus_o(bus_in), .dev_data_i(bus_out), .dev_oe_i(bus_oe));
  task automatic end_sim;
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic st(output logic [7:0] r);
    host.xfer(1'b0, 1'b0, 8'h00, r);
  endtask : st
  task automatic poll;
    logic [7:0] r;
    int n;
    n = 0;
    r = 8'h80;
    while (r[7] !== 1'b0 && n < 2000) begin
      st(r);
      n++;
    end
    if (n >= 2000) failures++;
  endtask : poll
  task automatic cmd(input logic [7:0] c);
    logic [7:0] r;
    host.xfer(1'b0, 1'b1, c, r);
    poll();
  endtask : cmd
  task automatic step;
    int yl;
    yl = w8 ? 7 : 10;
    if (sel) y = dir ? (y == yl ? 0 : y + 1) : (y == 0 ? yl : y - 1);
    else x = dir ? (x == 47 ? 0 : x + 1) : (x == 0 ? 47 : x - 1);
  endtask : step
  // write n words from (xa, pa), re-address, one stale read, then read them back
  task automatic run(input int m8, input int ms, input int md, input int xa, input int pa, input int n);
    logic [7:0] r, q;
    w8 = m8;
    sel = ms;
    dir = md;
    cmd(8'(m8));
    cmd(8'(4 + ms * 2 + md));
    cmd(8'(8'h80 | xa));
    cmd(8'(8'h20 | pa));
    x = xa;
    y = pa;
    for (int i = 0; i < n; i++) begin
      r = 8'($random(seed));
      host.xfer(1'b1, 1'b1, r, q);
      mem[x][y] = r & (w8 ? 8'hff : (y == 10 ? 8'h0f : 8'h3f));
      step();
      poll();
    end
    cmd(8'(8'h80 | xa));
    cmd(8'(8'h20 | pa));
    x = xa;
    y = pa;
    host.xfer(1'b1, 1'b0, 8'h00, r);
    poll();
    for (int i = 0; i < n; i++) begin
      host.xfer(1'b1, 1'b0, 8'h00, r);
      `CHK(r, mem[x][y])
      step();
      poll();
    end
  endtask : run
  initial begin
    repeat (12) @(negedge mclk_i);
    reset_i = 1'b0;
    st(b);
    `CHK(b, 8'h43)
    run(1, 0, 1, 46, 0, 4);
    run(1, 1, 0, 5, 0, 3);
    run(0, 1, 1, 9, 10, 2);
    run(0, 0, 0, 1, 3, 3);
    // fifo holds four, the fifth command is dropped
    for (int i = 0; i < 4; i++) host.xfer(1'b0, 1'b1, 8'h04, b);
    host.xfer(1'b0, 1'b1, 8'h07, b);
    poll();
    st(b);
    `CHK(b[1:0], 2'b00)
    standby_n_i = 1'b0;
    host.xfer(1'b0, 1'b1, 8'h03, b);
    standby_n_i = 1'b1;
    poll();
    st(b);
    `CHK(b[5], 1'b0)
    cmd(8'h03);
    repeat (2000) @(negedge mclk_i);
    `CHK($onehot(rows), 1'b1)
    rst_n_i = 1'b0;
    duty_sel = 2'h0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t0 = cyc;
    st(b);
    `CHK(b, 8'h43)
    `CHK(rows, 48'h0)
    // one full row at ram line 20, scrolled to the top of a 1/16 frame
    cmd(8'h94);
    cmd(8'h20);
    for (int i = 0; i < 8; i++) begin
      b = 8'($random(seed));
      exp_row[i * 8 +: 8] = b;
      host.xfer(1'b1, 1'b1, b, q);
      poll();
    end
    cmd(8'h54);
    cmd(8'h03);
    @(posedge frame);
    `CHK((cyc - t0 >= 15 * 8 * divs[3] - 4) && (cyc - t0 <= 15 * 8 * divs[3] + 4), 1'b1)
    repeat (3) @(negedge mclk_i);
    `CHK(cols, exp_row)
    `CHK(rows, 48'h1)
    cmd(8'h02);
    `CHK(cols, 64'h0)
    cmd(8'h03);
    `CHK(cols, exp_row)
    for (int f = 0; f < 4; f++) begin
      freq_sel = 2'(f);
      cmd(8'h02);
      t0 = cyc;
      cmd(8'h02);
      `CHK((cyc - t0 >= divs[f] - 12) && (cyc - t0 <= divs[f] + 12), 1'b1)
    end
    end_sim();
  end
  initial begin
    #900000;
    failures++;
    end_sim();
  end
endmodule : glcd_ctrl_tb

bind glcd_ctrl glcd_ctrl_checker chk (.mclk_i(mclk_i), .reset_i(reset_i), .rst_n_i(rst_n_i),
  .standby_n_i(standby_n_i), .osc_frequency_straps_i(osc_frequency_straps_i),
  .scan_duty_straps_i(scan_duty_straps_i), .data_sel_i(data_sel_i), .write_n_i(write_n_i),
  .strobe_n_i(strobe_n_i), .host_data_bus_i(host_data_bus_i), .host_data_bus_o(host_data_bus_o),
  .host_data_bus_oe_o(host_data_bus_oe_o), .column_outputs_o(column_outputs_o),
  .row_outputs_o(row_outputs_o), .frame_pulse_o(frame_pulse_o));
